// >>> src/tdm_irq_pkg.sv
package tdm_irq_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int CHAN_W = 5;
    localparam int FRAME_CNT_W = 9;

    localparam logic [ADDR_W-1:0] ADDR_CONTROL_1 = 6'h20;
    localparam logic [ADDR_W-1:0] ADDR_VECTOR = 6'h22;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_1 = 6'h24;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS_2 = 6'h25;
    localparam logic [ADDR_W-1:0] ADDR_IMAGE_1 = 6'h26;
    localparam logic [ADDR_W-1:0] ADDR_IMAGE_2 = 6'h27;
    localparam logic [ADDR_W-1:0] ADDR_MASK_1 = 6'h28;
    localparam logic [ADDR_W-1:0] ADDR_MASK_2 = 6'h29;
    localparam logic [ADDR_W-1:0] ADDR_PATTERN_1 = 6'h2a;
    localparam logic [ADDR_W-1:0] ADDR_PATTERN_2 = 6'h2b;
    localparam logic [ADDR_W-1:0] ADDR_CHANNEL_1 = 6'h2c;
    localparam logic [ADDR_W-1:0] ADDR_CHANNEL_2 = 6'h2d;

    localparam int PATH1_REQUEST_ENABLE = 0;
    localparam int PATH2_REQUEST_ENABLE = 1;
    localparam int PATH1_DETECT_KIND = 2;
    localparam int PATH2_DETECT_KIND = 3;
    localparam int INTERRUPT_CLEAR_ALL = 6;
    localparam logic [DATA_W-1:0] CONTROL_WRITE_MASK = 8'h7f;

    localparam int VECTOR_PATH1_BIT = 0;
    localparam int VECTOR_PATH2_BIT = 1;
    localparam logic [DATA_W-1:0] VECTOR_USER_MASK = 8'hfc;

    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] STATIC_FLAG = 8'h01;
    localparam logic [3:0] CHANNEL_LAST_HALF = 4'hf;
    localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_START = 9'h000;
    localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_STEP = 9'h001;
    localparam int CHAN_LSB = 4;

    typedef struct packed {
        logic valid;
        logic [CHAN_W-1:0] channel;
        logic [DATA_W-1:0] data;
    } channel_byte_type;

    typedef struct packed {
        logic [DATA_W-1:0] pattern;
        logic [DATA_W-1:0] mask;
        logic [CHAN_W-1:0] channel;
        logic dynamic;
    } path_config_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACCESS = 2'b01,
        BUS_VECTOR = 2'b10
    } bus_state_type;

endpackage

// >>> src/tdm_watch_path.sv
`timescale 1ns/10ps
module tdm_watch_path
    import tdm_irq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire path_config_type cfg_i,
    input wire channel_byte_type byte_i,
    input wire logic image_read_i,
    input wire logic flags_read_i,
    input wire logic clear_all_i,
    output logic [DATA_W-1:0] image_o,
    output logic [DATA_W-1:0] flags_o,
    output logic pending_o
);

    logic [DATA_W-1:0] image_ff;
    logic [DATA_W-1:0] flags_ff;
    logic [DATA_W-1:0] prev_ff;
    logic prev_ok_ff;
    logic pending_ff;

    wire hit_w = byte_i.valid && (byte_i.channel == cfg_i.channel);
    wire [DATA_W-1:0] diff_w = (byte_i.data ^ cfg_i.pattern) & ~cfg_i.mask; // [R4]
    wire [DATA_W-1:0] rise_w = ~prev_ff & byte_i.data & ~cfg_i.pattern & cfg_i.mask;
    wire [DATA_W-1:0] fall_w = prev_ff & ~byte_i.data & cfg_i.pattern & ~cfg_i.mask;
    wire [DATA_W-1:0] tog_w = (prev_ff ^ byte_i.data) & cfg_i.pattern & cfg_i.mask;
    wire [DATA_W-1:0] cause_w = rise_w | fall_w | tog_w; // [R11]
    wire static_w = !cfg_i.dynamic && (diff_w == REG_RESET);
    wire dynamic_w = cfg_i.dynamic && prev_ok_ff && (cause_w != REG_RESET);
    wire event_w = run_i && hit_w && !pending_ff && (static_w || dynamic_w);
    wire capture_w = hit_w && !pending_ff;
    wire release_w = clear_all_i || (cfg_i.dynamic ? flags_read_i : image_read_i);

    // capture beats a read-clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            image_ff <= REG_RESET;
        end else if (capture_w) begin
            image_ff <= byte_i.data; // [R3] [R22] [R13]
        end else if (image_read_i || clear_all_i) begin
            image_ff <= REG_RESET; // [R6] [R18]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_ff <= REG_RESET;
        end else if (event_w) begin
            flags_ff <= cfg_i.dynamic ? cause_w : STATIC_FLAG; // [R8] [R9]
        end else if (flags_read_i || clear_all_i) begin
            flags_ff <= REG_RESET; // [R9] [R18]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_ff <= 1'b0;
            prev_ff <= REG_RESET;
            prev_ok_ff <= 1'b0;
        end else begin
            if (event_w) begin
                pending_ff <= 1'b1; // [R5] [R13]
            end else if (release_w) begin
                pending_ff <= 1'b0; // [R18]
            end
            if (hit_w) begin
                prev_ff <= byte_i.data; // [R12]
                prev_ok_ff <= 1'b1;
            end
        end
    end

    assign image_o = image_ff;
    assign flags_o = flags_ff;
    assign pending_o = pending_ff;

    property p_static_flag;
        @(posedge clk_i) disable iff (rst_i)
        (event_w && !cfg_i.dynamic) |=> (flags_ff == STATIC_FLAG) && pending_ff;
    endproperty
    a_static_flag: assert property (p_static_flag) else $error("static flag not set"); // [R8]

    property p_masked_match;
        @(posedge clk_i) disable iff (rst_i)
        (run_i && hit_w && !pending_ff && !cfg_i.dynamic
            && (((byte_i.data ^ cfg_i.pattern) & ~cfg_i.mask) == REG_RESET))
            |=> pending_ff && (image_ff == $past(byte_i.data));
    endproperty
    a_masked_match: assert property (p_masked_match) else $error("masked match missed"); // [R4]

    property p_frozen;
        @(posedge clk_i) disable iff (rst_i)
        (pending_ff && !image_read_i && !clear_all_i) |=> $stable(image_ff);
    endproperty
    a_frozen: assert property (p_frozen) else $error("image changed while frozen"); // [R5]

    property p_image_read;
        @(posedge clk_i) disable iff (rst_i)
        (image_read_i && !capture_w) |=> (image_ff == REG_RESET);
    endproperty
    a_image_read: assert property (p_image_read) else $error("image not cleared by read"); // [R6]

    property p_dynamic_cause;
        @(posedge clk_i) disable iff (rst_i)
        (event_w && cfg_i.dynamic) |=> (flags_ff == $past(cause_w)) && pending_ff;
    endproperty
    a_dynamic_cause: assert property (p_dynamic_cause) else $error("dynamic flags wrong"); // [R11]

endmodule

// >>> src/tdm_channel_match_interrupt.sv
`timescale 1ns/10ps
// Notes on behaviour
// [R1] interrupts are produced only while the processor mode input is high
// [R2] two independent paths, each watching one selected channel 0 to 31
// [R3] static: capture channel byte, compare with pattern, interrupt on unmasked match
// [R4] static: mask bit 1 makes that compare bit a don't-care
// [R5] after a static interrupt the image stays frozen until it is read
// [R6] image holds the interrupting byte; reading returns it then clears it
// [R7] processor clears a static interrupt by reading image or setting clear-all
// [R8] static interrupt sets bit 0 of the path flag register
// [R9] dynamic interrupt sets flag bits of changed positions; read clears flags
// [R10] processor clears a dynamic interrupt by reading flags or setting clear-all
// [R11] dynamic: pattern/mask pair 00 off, 01 rise, 10 fall, 11 any change
// [R12] dynamic compares each bit with its value in the previous frame
// [R13] dynamic interrupt also freezes the channel byte in the image register
// [R14] shared vector: processor writes bits 7..2, device sets path bits 1..0
// [R15] while acknowledge is asserted the vector is driven onto the data bus
// [R16] processor may skip vectoring by never asserting acknowledge
// [R17] path enable bit gates the request; kind bit picks static or dynamic
// [R18] clear-all clears images, flags and vector path bits
// [R19] kind bit 0 static, 1 dynamic; bit 2 path 1, bit 3 path 2
// [R20] clear-all bit returns to zero by itself after clearing
// [R21] request stays asserted while any enabled path is pending
// [R22] unfrozen image refreshes each frame at the end of its channel
module tdm_channel_match_interrupt
    import tdm_irq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic processor_mode_i,
    input wire logic bit_clock_i,
    input wire logic frame_pulse_n_i,
    input wire logic serial_input_stream_0_i,
    input wire logic chip_select_n_i,
    input wire logic data_strobe_n_i,
    input wire logic read_not_write_i,
    input wire logic [ADDR_W-1:0] address_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic interrupt_acknowledge_in_n_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_n_o,
    output logic dtack_n_o,
    output logic intr_request_n_o
);

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] target);
        reg_hit = (addr == target);
    endfunction

    // serial stream timing
    logic bit_clock_q_ff;
    logic [FRAME_CNT_W-1:0] frame_cnt_ff;
    logic [DATA_W-1:0] shift_ff;
    channel_byte_type rx_byte_ff;

    wire clock_fall_w = bit_clock_q_ff && !bit_clock_i;
    wire sample_w = clock_fall_w && frame_cnt_ff[0];
    wire chan_end_w = clock_fall_w && (frame_cnt_ff[3:0] == CHANNEL_LAST_HALF);
    wire [DATA_W-1:0] shift_next_w = {shift_ff[DATA_W-2:0], serial_input_stream_0_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_clock_q_ff <= 1'b0;
            frame_cnt_ff <= FRAME_CNT_START;
        end else begin
            bit_clock_q_ff <= bit_clock_i;
            if (clock_fall_w) begin
                frame_cnt_ff <= frame_pulse_n_i ? frame_cnt_ff + FRAME_CNT_STEP
                                                : FRAME_CNT_START;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_ff <= REG_RESET;
            rx_byte_ff <= '0;
        end else begin
            if (sample_w) begin
                shift_ff <= shift_next_w;
            end
            rx_byte_ff.valid <= chan_end_w; // [R22]
            if (chan_end_w) begin
                rx_byte_ff.channel <= frame_cnt_ff[FRAME_CNT_W-1:CHAN_LSB];
                rx_byte_ff.data <= shift_next_w;
            end
        end
    end

    // register file
    logic [DATA_W-1:0] control_ff;
    logic [DATA_W-1:0] vector_ff;
    logic [DATA_W-1:0] channel_1_ff;
    logic [DATA_W-1:0] channel_2_ff;
    logic [DATA_W-1:0] pattern_1_ff;
    logic [DATA_W-1:0] pattern_2_ff;
    logic [DATA_W-1:0] mask_1_ff;
    logic [DATA_W-1:0] mask_2_ff;

    bus_state_type state_ff;
    bus_state_type nxt_state;
    logic [DATA_W-1:0] data_ff;
    logic data_oe_n_ff;
    logic dtack_n_ff;
    logic request_n_ff;

    wire strobe_w = !chip_select_n_i && !data_strobe_n_i;
    wire ack_w = !interrupt_acknowledge_in_n_i;
    wire take_w = (state_ff == BUS_IDLE) && !ack_w && strobe_w;
    wire read_take_w = take_w && read_not_write_i;
    wire write_take_w = take_w && !read_not_write_i;

    wire wr_control_w = write_take_w && reg_hit(address_i, ADDR_CONTROL_1);
    wire wr_vector_w = write_take_w && reg_hit(address_i, ADDR_VECTOR);
    wire wr_channel_1_w = write_take_w && reg_hit(address_i, ADDR_CHANNEL_1);
    wire wr_channel_2_w = write_take_w && reg_hit(address_i, ADDR_CHANNEL_2);
    wire wr_pattern_1_w = write_take_w && reg_hit(address_i, ADDR_PATTERN_1);
    wire wr_pattern_2_w = write_take_w && reg_hit(address_i, ADDR_PATTERN_2);
    wire wr_mask_1_w = write_take_w && reg_hit(address_i, ADDR_MASK_1);
    wire wr_mask_2_w = write_take_w && reg_hit(address_i, ADDR_MASK_2);
    wire rd_image_1_w = read_take_w && reg_hit(address_i, ADDR_IMAGE_1);
    wire rd_image_2_w = read_take_w && reg_hit(address_i, ADDR_IMAGE_2);
    wire rd_flags_1_w = read_take_w && reg_hit(address_i, ADDR_FLAGS_1);
    wire rd_flags_2_w = read_take_w && reg_hit(address_i, ADDR_FLAGS_2);

    wire clear_all_w = control_ff[INTERRUPT_CLEAR_ALL];
    wire run_1_w = processor_mode_i && control_ff[PATH1_REQUEST_ENABLE]; // [R1] [R17]
    wire run_2_w = processor_mode_i && control_ff[PATH2_REQUEST_ENABLE]; // [R1] [R17]

    path_config_type cfg_1_w;
    path_config_type cfg_2_w;
    assign cfg_1_w = '{pattern: pattern_1_ff, mask: mask_1_ff,
                       channel: channel_1_ff[CHAN_W-1:0],
                       dynamic: control_ff[PATH1_DETECT_KIND]}; // [R19] [R2]
    assign cfg_2_w = '{pattern: pattern_2_ff, mask: mask_2_ff,
                       channel: channel_2_ff[CHAN_W-1:0],
                       dynamic: control_ff[PATH2_DETECT_KIND]}; // [R19] [R2]

    logic [DATA_W-1:0] image_1_w;
    logic [DATA_W-1:0] image_2_w;
    logic [DATA_W-1:0] flags_1_w;
    logic [DATA_W-1:0] flags_2_w;
    logic pending_1_w;
    logic pending_2_w;

    tdm_watch_path u_path_1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run_1_w),
        .cfg_i(cfg_1_w),
        .byte_i(rx_byte_ff),
        .image_read_i(rd_image_1_w),
        .flags_read_i(rd_flags_1_w),
        .clear_all_i(clear_all_w),
        .image_o(image_1_w),
        .flags_o(flags_1_w),
        .pending_o(pending_1_w)
    );

    tdm_watch_path u_path_2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run_2_w),
        .cfg_i(cfg_2_w),
        .byte_i(rx_byte_ff),
        .image_read_i(rd_image_2_w),
        .flags_read_i(rd_flags_2_w),
        .clear_all_i(clear_all_w),
        .image_o(image_2_w),
        .flags_o(flags_2_w),
        .pending_o(pending_2_w)
    );

    logic [DATA_W-1:0] nxt_vector;
    always_comb begin
        nxt_vector = vector_ff;
        if (wr_vector_w) begin
            nxt_vector = (data_i & VECTOR_USER_MASK) | (vector_ff & ~VECTOR_USER_MASK);
        end
        nxt_vector[VECTOR_PATH1_BIT] = pending_1_w; // [R14] [R18]
        nxt_vector[VECTOR_PATH2_BIT] = pending_2_w; // [R14] [R18]
    end

    // clear-all stays set for one cycle, during which the paths clear
    logic [DATA_W-1:0] nxt_control;
    assign nxt_control = wr_control_w ? (data_i & CONTROL_WRITE_MASK)
                                      : (control_ff & ~(8'h01 << INTERRUPT_CLEAR_ALL)); // [R20]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_ff <= REG_RESET;
            vector_ff <= REG_RESET;
        end else begin
            control_ff <= nxt_control;
            vector_ff <= nxt_vector;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_1_ff <= REG_RESET;
            channel_2_ff <= REG_RESET;
            pattern_1_ff <= REG_RESET;
            pattern_2_ff <= REG_RESET;
            mask_1_ff <= REG_RESET;
            mask_2_ff <= REG_RESET;
        end else begin
            if (wr_channel_1_w) channel_1_ff <= data_i;
            if (wr_channel_2_w) channel_2_ff <= data_i;
            if (wr_pattern_1_w) pattern_1_ff <= data_i;
            if (wr_pattern_2_w) pattern_2_ff <= data_i;
            if (wr_mask_1_w) mask_1_ff <= data_i;
            if (wr_mask_2_w) mask_2_ff <= data_i;
        end
    end

    logic [DATA_W-1:0] rdata_w;
    always_comb begin
        if (reg_hit(address_i, ADDR_CONTROL_1)) begin
            rdata_w = control_ff;
        end else if (reg_hit(address_i, ADDR_VECTOR)) begin
            rdata_w = vector_ff;
        end else if (reg_hit(address_i, ADDR_FLAGS_1)) begin
            rdata_w = flags_1_w;
        end else if (reg_hit(address_i, ADDR_FLAGS_2)) begin
            rdata_w = flags_2_w;
        end else if (reg_hit(address_i, ADDR_IMAGE_1)) begin
            rdata_w = image_1_w;
        end else if (reg_hit(address_i, ADDR_IMAGE_2)) begin
            rdata_w = image_2_w;
        end else if (reg_hit(address_i, ADDR_MASK_1)) begin
            rdata_w = mask_1_ff;
        end else if (reg_hit(address_i, ADDR_MASK_2)) begin
            rdata_w = mask_2_ff;
        end else if (reg_hit(address_i, ADDR_PATTERN_1)) begin
            rdata_w = pattern_1_ff;
        end else if (reg_hit(address_i, ADDR_PATTERN_2)) begin
            rdata_w = pattern_2_ff;
        end else if (reg_hit(address_i, ADDR_CHANNEL_1)) begin
            rdata_w = channel_1_ff;
        end else if (reg_hit(address_i, ADDR_CHANNEL_2)) begin
            rdata_w = channel_2_ff;
        end else begin
            rdata_w = REG_RESET;
        end
    end

    // bus handshake: one access per strobe, acknowledge has priority
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            BUS_IDLE: begin
                if (ack_w) nxt_state = BUS_VECTOR;
                else if (strobe_w) nxt_state = BUS_ACCESS;
            end
            BUS_ACCESS: begin
                if (!strobe_w) nxt_state = BUS_IDLE;
            end
            BUS_VECTOR: begin
                if (!ack_w) nxt_state = BUS_IDLE;
            end
            default: nxt_state = BUS_IDLE;
        endcase
    end

    wire drive_vector_w = (nxt_state == BUS_VECTOR);
    wire drive_read_w = (nxt_state == BUS_ACCESS) && read_not_write_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= BUS_IDLE;
            data_ff <= REG_RESET;
            data_oe_n_ff <= 1'b1;
            dtack_n_ff <= 1'b1;
            request_n_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            if (drive_vector_w) begin
                data_ff <= nxt_vector; // [R15]
            end else if (read_take_w) begin
                data_ff <= rdata_w;
            end
            data_oe_n_ff <= !(drive_vector_w || drive_read_w); // [R15]
            dtack_n_ff <= (nxt_state == BUS_IDLE);
            request_n_ff <= !((run_1_w && pending_1_w) || (run_2_w && pending_2_w)); // [R21]
        end
    end

    assign data_o = data_ff;
    assign data_oe_n_o = data_oe_n_ff;
    assign dtack_n_o = dtack_n_ff;
    assign intr_request_n_o = request_n_ff;

    sequence s_ack_held;
        ack_w [*2];
    endsequence

    property p_vector_out;
        @(posedge clk_i) disable iff (rst_i)
        (state_ff == BUS_IDLE) ##0 s_ack_held |-> !data_oe_n_o && (data_o == vector_ff);
    endproperty
    a_vector_out: assert property (p_vector_out) else $error("vector not driven"); // [R15]

    property p_request;
        @(posedge clk_i) disable iff (rst_i)
        ((run_1_w && pending_1_w) || (run_2_w && pending_2_w)) |=> !intr_request_n_o;
    endproperty
    a_request: assert property (p_request) else $error("request not asserted"); // [R21]

    property p_mode_off;
        @(posedge clk_i) disable iff (rst_i)
        !processor_mode_i |=> intr_request_n_o;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("request outside mode 1"); // [R1]

    property p_clear_self;
        @(posedge clk_i) disable iff (rst_i)
        (clear_all_w && !wr_control_w) |=> !clear_all_w
            && (!pending_1_w || !$past(pending_1_w))
            && (!pending_2_w || !$past(pending_2_w));
    endproperty
    a_clear_self: assert property (p_clear_self) else $error("clear-all stuck"); // [R20]

    property p_path_bits;
        @(posedge clk_i) disable iff (rst_i)
        ##1 (vector_ff[VECTOR_PATH1_BIT] == $past(pending_1_w))
            && (vector_ff[VECTOR_PATH2_BIT] == $past(pending_2_w));
    endproperty
    a_path_bits: assert property (p_path_bits) else $error("vector path bits wrong"); // [R14]

    property p_disabled_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (!control_ff[PATH1_REQUEST_ENABLE] && !control_ff[PATH2_REQUEST_ENABLE])
            |=> intr_request_n_o;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("request while disabled"); // [R17]

    property p_bus_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (!ack_w && !strobe_w) |=> data_oe_n_o && dtack_n_o;
    endproperty
    a_bus_quiet: assert property (p_bus_quiet) else $error("bus driven without request"); // [R15]

endmodule

// >>> test/tdm_stream_source.sv
`timescale 1ns/10ps
module tdm_stream_source (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [255:0] frame_i,
    output logic bit_clock_o,
    output logic frame_pulse_n_o,
    output logic serial_o
);
    logic [8:0] cnt_ff;
    logic [2:0] ph_ff;
    logic [255:0] held_ff;
    // frame contents are latched at frame start so a change never splits a byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 9'h1ff;
            ph_ff <= 3'h0;
            held_ff <= frame_i;
            bit_clock_o <= 1'b1;
            frame_pulse_n_o <= 1'b1;
            serial_o <= 1'b0;
        end else begin
            ph_ff <= (ph_ff == 3'h5) ? 3'h0 : ph_ff + 3'h1;
            if (ph_ff == 3'h0) begin
                cnt_ff <= cnt_ff + 9'h001;
                bit_clock_o <= 1'b1;
                frame_pulse_n_o <= (cnt_ff != 9'h1ff);
                if (cnt_ff == 9'h1ff) begin
                    held_ff <= frame_i;
                end
                serial_o <= held_ff[{cnt_ff[8:4] + 5'h0, ~cnt_ff[3:1]} + 8'h00];
            end else if (ph_ff == 3'h3) begin
                bit_clock_o <= 1'b0;
            end
        end
    end
endmodule

// >>> test/tdm_channel_match_interrupt_tb.sv
`timescale 1ns/10ps
module tdm_channel_match_interrupt_tb;
    import tdm_irq_pkg::*;
    localparam int FRAME = 3072;
    logic clk_i, rst_i, pmode, bclk, fp_n, sdat, cs_n, ds_n, rnw, ack_n;
    logic [5:0] addr;
    logic [7:0] wdata, q, b, mk, lfsr_ff;
    logic [255:0] frame;
    logic [4:0] ch;
    logic [7:0] data_o;
    logic oe_n, dtack_n, irq_n;
    int err_total, n_compared, cyc;

    tdm_stream_source src (.clk_i(clk_i), .rst_i(rst_i), .frame_i(frame),
        .bit_clock_o(bclk), .frame_pulse_n_o(fp_n), .serial_o(sdat));
    tdm_channel_match_interrupt uut (.clk_i(clk_i), .rst_i(rst_i), .processor_mode_i(pmode),
        .bit_clock_i(bclk), .frame_pulse_n_i(fp_n), .serial_input_stream_0_i(sdat),
        .chip_select_n_i(cs_n), .data_strobe_n_i(ds_n), .read_not_write_i(rnw),
        .address_i(addr), .data_i(wdata), .interrupt_acknowledge_in_n_i(ack_n),
        .data_o(data_o), .data_oe_n_o(oe_n), .dtack_n_o(dtack_n), .intr_request_n_o(irq_n));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // per bit: mask selects rising edges, pattern selects falling edges
    function automatic logic [7:0] dyn(input logic [7:0] p, c, pat, m);
        return (~p & c & m) | (p & ~c & pat);
    endfunction
    task automatic wrap_up;
        if (err_total == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // kind 0 write, 1 read, 2 vector acknowledge
    task automatic xfer(input int kind, input logic [5:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        #2;
        if (kind == 2) begin
            ack_n = 1'b0;
        end else begin
            cs_n = 1'b0;
            ds_n = 1'b0;
            rnw = (kind == 1);
            addr = a;
            wdata = d;
        end
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (dtack_n !== 1'b0 && n < 20);
        q = data_o;
        if (n >= 20) chk(8'hee, 8'h00);
        if (kind != 0) chk({7'h0, oe_n}, 8'h00);
        #2;
        cs_n = 1'b1;
        ds_n = 1'b1;
        ack_n = 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (dtack_n !== 1'b1 && n < 20);
        if (n >= 20) chk(8'hee, 8'h00);
        if (kind != 0) chk({7'h0, oe_n}, 8'h01);
        #2;
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq_n !== 1'b0 && n < 3 * FRAME) begin
            @(posedge clk_i);
            n++;
        end
        chk({7'h0, irq_n}, 8'h00);
        #2;
    endtask
    task automatic quiet(input int k);
        int lows;
        lows = 0;
        repeat (k * FRAME) begin
            @(posedge clk_i);
            if (irq_n !== 1'b1) lows++;
        end
        chk({7'h0, lows != 0}, 8'h00);
        #2;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        err_total = 0;
        n_compared = 0;
        cyc = 0;
        lfsr_ff = 8'h14;
        rst_i = 1'b1;
        pmode = 1'b0;
        cs_n = 1'b1;
        ds_n = 1'b1;
        rnw = 1'b1;
        ack_n = 1'b1;
        addr = 6'h00;
        wdata = 8'h00;
        frame = '0;
        repeat (3) @(posedge clk_i);
        #2;
        rst_i = 1'b0;
        for (int a = 6'h20; a <= 6'h2d; a++) begin
            xfer(1, a[5:0], 8'h00);
            chk(q, REG_RESET);
        end
        xfer(1, 6'h3f, 8'h00);
        chk(q, 8'h00);
        xfer(0, ADDR_VECTOR, 8'hff);
        xfer(1, ADDR_VECTOR, 8'h00);
        chk(q, 8'hfc);
        lfsr_ff = lfsr(lfsr_ff);
        ch = lfsr_ff[4:0];
        lfsr_ff = lfsr(lfsr_ff);
        b = lfsr_ff;
        lfsr_ff = lfsr(lfsr_ff);
        mk = lfsr_ff & 8'h7f;
        frame[ch * 8 +: 8] = b;
        xfer(0, ADDR_CHANNEL_1, {3'h0, ch});
        xfer(0, ADDR_PATTERN_1, b ^ mk);
        xfer(0, ADDR_MASK_1, mk);
        xfer(0, ADDR_CONTROL_1, 8'h01);
        quiet(2);
        pmode = 1'b1;
        wait_irq();
        xfer(2, 6'h00, 8'h00);
        chk(q, 8'hfd);
        xfer(1, ADDR_FLAGS_1, 8'h00);
        chk(q, STATIC_FLAG);
        frame[ch * 8 +: 8] = b ^ 8'h80;
        repeat (2 * FRAME) @(posedge clk_i);
        xfer(1, ADDR_IMAGE_1, 8'h00);
        chk(q, b);
        repeat (4) @(posedge clk_i);
        chk({7'h0, irq_n}, 8'h01);
        repeat (FRAME) @(posedge clk_i);
        xfer(1, ADDR_IMAGE_1, 8'h00);
        chk(q, b ^ 8'h80);
        ch = ch ^ 5'h01;
        frame[ch * 8 +: 8] = 8'h04;
        xfer(0, ADDR_CHANNEL_2, {3'h0, ch});
        xfer(0, ADDR_PATTERN_2, 8'h0c);
        xfer(0, ADDR_MASK_2, 8'h0a);
        xfer(0, ADDR_CONTROL_1, 8'h0a);
        quiet(2);
        frame[ch * 8 +: 8] = 8'h0b;
        wait_irq();
        xfer(2, 6'h00, 8'h00);
        chk(q, 8'hfe);
        xfer(1, ADDR_IMAGE_2, 8'h00);
        chk(q, 8'h0b);
        xfer(1, ADDR_FLAGS_2, 8'h00);
        chk(q, dyn(8'h04, 8'h0b, 8'h0c, 8'h0a));
        repeat (4) @(posedge clk_i);
        chk({7'h0, irq_n}, 8'h01);
        #2;
        frame[ch * 8 +: 8] = 8'h04;
        wait_irq();
        xfer(0, ADDR_CONTROL_1, 8'h4a);
        repeat (4) @(posedge clk_i);
        chk({7'h0, irq_n}, 8'h01);
        xfer(1, ADDR_FLAGS_2, 8'h00);
        chk(q, 8'h00);
        xfer(1, ADDR_CONTROL_1, 8'h00);
        chk(q, 8'h0a);
        xfer(2, 6'h00, 8'h00);
        chk(q, 8'hfc);
        wrap_up();
    end
endmodule
